// ===== src/dma_controller.sv
// Purpose: Two-channel transfer engine with register port and bus master
// Assumes: Bus slave answers each request with busAck, after any number of wait clocks
// Notes: Pins xfer_request_in_ch* and nmiIn pass two flip-flops first
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
module dma_controller (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic xfer_request_in_ch0,
   input wire logic xfer_request_in_ch1,
   input wire logic [2:0] periphReqCh0,
   input wire logic [2:0] periphReqCh1,
   input wire logic nmiIn,
   input wire logic busAck,
   input wire logic busError,
   input wire logic [31:0] busRdata,
   output logic busReq,
   output logic busWrite,
   output logic [31:0] busAddr,
   output logic [1:0] busSize,
   output logic [31:0] busWdata,
   output logic burst_hint_out,
   output logic xfer_ack_out_ch0,
   output logic xfer_ack_out_ch1,
   output logic irqCh0,
   output logic irqCh1
);
   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [1:0][31:0] src;
      logic [1:0][31:0] dst;
      logic [1:0][dma_pkg::CNT_W-1:0] cnt;
      logic [1:0][dma_pkg::CTL_W-1:0] ctl;
      logic [1:0][31:0] vec;
      logic [1:0][7:0] rsel;
      logic [dma_pkg::OP_W-1:0] op;
      logic [1:0] teSeen;
      logic [1:0] opSeen;
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] prevAct;
      logic [1:0] pend;
      logic nmiS1;
      logic nmiS2;
      dma_pkg::fsm_type fsm;
      logic ch;
      logic lastCh;
      logic [1:0] beat;
      logic [3:0][31:0] buffer;
      logic [31:0] regRdata;
      logic busReq;
      logic busWrite;
      logic [31:0] busAddr;
      logic [1:0] busSize;
      logic [31:0] busWdata;
      logic burst;
      logic [1:0] ack;
      logic [1:0] irq;
   } state_type;
   state_type s;
   state_type next_s;
   logic [1:0] act, en, req;
   logic [2:0] periph;
   logic [1:0] rs;
   logic start, pick, finish;
   logic [1:0] lastBeat, ts;
   logic [dma_pkg::CNT_W-1:0] cntStep;
   logic single;
   logic [15:0] cw;
   logic [31:0] rdv;
   logic [2:0] rk;
   logic rc;
   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   // Address to register kind and channel
   function automatic logic [3:0] decode(input logic [31:0] a);
      unique case (a)
         dma_pkg::OFS_C0_SRC: decode = {1'b0, dma_pkg::K_SRC};
         dma_pkg::OFS_C0_DST: decode = {1'b0, dma_pkg::K_DST};
         dma_pkg::OFS_C0_CNT: decode = {1'b0, dma_pkg::K_CNT};
         dma_pkg::OFS_C0_CTL: decode = {1'b0, dma_pkg::K_CTL};
         dma_pkg::OFS_C0_VEC: decode = {1'b0, dma_pkg::K_VEC};
         dma_pkg::OFS_C0_RSEL: decode = {1'b0, dma_pkg::K_RSEL};
         dma_pkg::OFS_C1_SRC: decode = {1'b1, dma_pkg::K_SRC};
         dma_pkg::OFS_C1_DST: decode = {1'b1, dma_pkg::K_DST};
         dma_pkg::OFS_C1_CNT: decode = {1'b1, dma_pkg::K_CNT};
         dma_pkg::OFS_C1_CTL: decode = {1'b1, dma_pkg::K_CTL};
         dma_pkg::OFS_C1_VEC: decode = {1'b1, dma_pkg::K_VEC};
         dma_pkg::OFS_C1_RSEL: decode = {1'b1, dma_pkg::K_RSEL};
         dma_pkg::OFS_OP: decode = {1'b0, dma_pkg::K_OP};
         default: decode = {1'b0, dma_pkg::K_NONE};
      endcase
   endfunction : decode
   // Address step for a unit size
   function automatic logic [31:0] stepOf(input logic [1:0] t);
      unique case (t)
         dma_pkg::TS_BYTE: stepOf = dma_pkg::STEP_BYTE;
         dma_pkg::TS_WORD: stepOf = dma_pkg::STEP_WORD;
         dma_pkg::TS_LONG: stepOf = dma_pkg::STEP_LONG;
         dma_pkg::TS_BLK16: stepOf = dma_pkg::STEP_BLK16;
      endcase
   endfunction : stepOf
   // Next address after one unit; block source always increments
   function automatic logic [31:0] addrNext(input logic [31:0] a,
         input logic [1:0] m, input logic [1:0] t, input logic force16);
      if (m == dma_pkg::AM_INC || (force16 && t == dma_pkg::TS_BLK16)) begin
         addrNext = a + stepOf(t);
      end else if (m == dma_pkg::AM_DEC) begin
         addrNext = a - stepOf(t);
      end else begin
         addrNext = a;
      end
   endfunction : addrNext
   // Beat address inside a unit
   function automatic logic [31:0] beatAddr(input logic [31:0] a,
         input logic [1:0] t, input logic [1:0] b);
      beatAddr = (t == dma_pkg::TS_BLK16) ? a + 32'({b, 2'b00}) : a;
   endfunction : beatAddr
   // Acknowledge only for the cycle that reaches the requesting device
   function automatic logic ackOn(input logic [15:0] c, input logic [1:0] r,
         input logic isWrite);
      ackOn = ~c[dma_pkg::CTL_AR] && r == dma_pkg::RSEL_PIN &&
         (c[dma_pkg::CTL_TA] || c[dma_pkg::CTL_AM] == isWrite);
   endfunction : ackOn
   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s = s;
      start = 1'b0;
      pick = 1'b0;
      finish = 1'b0;
      periph = 3'h0;
      rs = 2'h0;
      act = 2'h0;
      en = 2'h0;
      req = 2'h0;
      rdv = 32'h00000000;
      rk = dma_pkg::K_NONE;
      rc = 1'b0;
      // Pin synchronisers
      next_s.sync1 = {xfer_request_in_ch1, xfer_request_in_ch0};
      next_s.sync2 = s.sync1;
      next_s.nmiS1 = nmiIn;
      next_s.nmiS2 = s.nmiS1;
      next_s.regRdata = 32'h00000000;
      // Request detection per channel
      for (int c = 0; c < 2; c++) begin
         act[c] = s.sync2[c] ~^ s.ctl[c][dma_pkg::CTL_DL];
         next_s.prevAct[c] = act[c];
         if (act[c] && !s.prevAct[c] && s.ctl[c][dma_pkg::CTL_DS]) begin
            next_s.pend[c] = 1'b1;
         end
         en[c] = s.ctl[c][dma_pkg::CTL_DE] & ~s.ctl[c][dma_pkg::CTL_TE] &
            s.op[dma_pkg::OP_DME] & ~s.op[dma_pkg::OP_AE] &
            ~s.op[dma_pkg::OP_NMIF];
         rs = s.rsel[c][dma_pkg::RSEL_HI:dma_pkg::RSEL_LO];
         periph = (c == 0) ? periphReqCh0 : periphReqCh1;
         if (s.ctl[c][dma_pkg::CTL_AR]) begin
            req[c] = en[c];
         end else if (rs == dma_pkg::RSEL_PIN) begin
            req[c] = en[c] & (s.ctl[c][dma_pkg::CTL_DS] ? s.pend[c] : act[c]);
         end else begin
            req[c] = en[c] & periph[rs - 2'h1];
         end
      end
      // Register reads, data stand in the following cycle
      if (regRead) begin
         {rc, rk} = decode(regAddr);
         unique case (rk)
            dma_pkg::K_SRC: rdv = s.src[rc];
            dma_pkg::K_DST: rdv = s.dst[rc];
            dma_pkg::K_CNT: rdv = 32'(s.cnt[rc]);
            dma_pkg::K_CTL: rdv = 32'(s.ctl[rc]);
            dma_pkg::K_VEC: rdv = s.vec[rc];
            dma_pkg::K_RSEL: rdv = 32'(s.rsel[rc]);
            dma_pkg::K_OP: rdv = 32'(s.op);
            dma_pkg::K_NONE: rdv = 32'h00000000;
         endcase
         next_s.regRdata = rdv;
         if (rk == dma_pkg::K_CTL && s.ctl[rc][dma_pkg::CTL_TE]) begin
            next_s.teSeen[rc] = 1'b1;
         end
         if (rk == dma_pkg::K_OP) begin
            next_s.opSeen = next_s.opSeen |
               {s.op[dma_pkg::OP_AE], s.op[dma_pkg::OP_NMIF]};
         end
      end
      // Register writes
      if (regWrite) begin
         {rc, rk} = decode(regAddr);
         unique case (rk)
            dma_pkg::K_SRC: next_s.src[rc] = regWdata;
            dma_pkg::K_DST: next_s.dst[rc] = regWdata;
            dma_pkg::K_CNT: next_s.cnt[rc] = regWdata[dma_pkg::CNT_W-1:0];
            dma_pkg::K_CTL: begin
               next_s.ctl[rc] = regWdata[dma_pkg::CTL_W-1:0];
               next_s.ctl[rc][dma_pkg::CTL_TE] = s.ctl[rc][dma_pkg::CTL_TE];
               if (!regWdata[dma_pkg::CTL_TE] && s.teSeen[rc]) begin
                  next_s.ctl[rc][dma_pkg::CTL_TE] = 1'b0;
                  next_s.teSeen[rc] = 1'b0;
               end
            end
            dma_pkg::K_VEC: next_s.vec[rc] = regWdata;
            dma_pkg::K_RSEL: next_s.rsel[rc] = regWdata[7:0];
            dma_pkg::K_OP: begin
               next_s.op[dma_pkg::OP_DME] = regWdata[dma_pkg::OP_DME];
               next_s.op[dma_pkg::OP_PR] = regWdata[dma_pkg::OP_PR];
               if (!regWdata[dma_pkg::OP_NMIF] && s.opSeen[0]) begin
                  next_s.op[dma_pkg::OP_NMIF] = 1'b0;
                  next_s.opSeen[0] = 1'b0;
               end
               if (!regWdata[dma_pkg::OP_AE] && s.opSeen[1]) begin
                  next_s.op[dma_pkg::OP_AE] = 1'b0;
                  next_s.opSeen[1] = 1'b0;
               end
            end
            dma_pkg::K_NONE: ;
         endcase
      end
      // Hardware-set flags, applied after software so a set wins
      if (s.nmiS2) begin
         next_s.op[dma_pkg::OP_NMIF] = 1'b1;
      end
      // Transfer sequencer, independent of the processor
      cw = s.ctl[s.ch];
      ts = cw[dma_pkg::CTL_TS_HI:dma_pkg::CTL_TS_LO];
      single = cw[dma_pkg::CTL_TA];
      lastBeat = (ts == dma_pkg::TS_BLK16) ? dma_pkg::BEATS_BLK16 : 2'h0;
      cntStep = (ts == dma_pkg::TS_BLK16) ? dma_pkg::CNT_BLK16 :
         dma_pkg::CNT_ONE;
      unique case (s.fsm)
         dma_pkg::ST_IDLE: begin
            if (req[0] || req[1]) begin
               start = 1'b1;
               if (req[0] && req[1]) begin
                  pick = s.op[dma_pkg::OP_PR] ? ~s.lastCh : 1'b0;
               end else begin
                  pick = req[1];
               end
            end
         end
         dma_pkg::ST_READ: begin
            if (busAck && busError) begin
               next_s.op[dma_pkg::OP_AE] = 1'b1;
               next_s.fsm = dma_pkg::ST_IDLE;
               next_s.busReq = 1'b0;
               next_s.ack = 2'h0;
               next_s.burst = 1'b0;
            end else if (busAck) begin
               next_s.buffer[s.beat] = busRdata;
               if (s.beat != lastBeat) begin
                  next_s.beat = 2'(s.beat + 2'h1);
                  next_s.busAddr = beatAddr(s.src[s.ch], ts, next_s.beat);
               end else if (single) begin
                  finish = 1'b1;
               end else begin
                  next_s.fsm = dma_pkg::ST_WRITE;
                  next_s.beat = 2'h0;
                  next_s.busWrite = 1'b1;
                  next_s.busAddr = s.dst[s.ch];
                  next_s.busWdata = next_s.buffer[0];
                  next_s.ack = 2'h0;
                  next_s.ack[s.ch] = ackOn(cw, s.rsel[s.ch][1:0], 1'b1);
               end
            end
         end
         dma_pkg::ST_WRITE: begin
            if (busAck && busError) begin
               next_s.op[dma_pkg::OP_AE] = 1'b1;
               next_s.fsm = dma_pkg::ST_IDLE;
               next_s.busReq = 1'b0;
               next_s.ack = 2'h0;
               next_s.burst = 1'b0;
            end else if (busAck) begin
               if (s.beat != lastBeat) begin
                  next_s.beat = 2'(s.beat + 2'h1);
                  next_s.busAddr = beatAddr(s.dst[s.ch], ts, next_s.beat);
                  next_s.busWdata = single ? 32'h00000000 :
                     s.buffer[next_s.beat];
               end else begin
                  finish = 1'b1;
               end
            end
         end
         default: next_s.fsm = dma_pkg::ST_IDLE;
      endcase
      // End of one unit: addresses, count, end flag
      if (finish) begin
         if (!single || cw[dma_pkg::CTL_AM]) begin
            next_s.src[s.ch] = addrNext(s.src[s.ch],
               cw[dma_pkg::CTL_SM_HI:dma_pkg::CTL_SM_LO], ts, 1'b1);
         end
         if (!single || !cw[dma_pkg::CTL_AM]) begin
            next_s.dst[s.ch] = addrNext(s.dst[s.ch],
               cw[dma_pkg::CTL_DM_HI:dma_pkg::CTL_DM_LO], ts, 1'b0);
         end
         next_s.cnt[s.ch] = dma_pkg::CNT_W'(s.cnt[s.ch] - cntStep);
         if (s.cnt[s.ch] == cntStep) begin
            next_s.ctl[s.ch][dma_pkg::CTL_TE] = 1'b1;
         end
         if (cw[dma_pkg::CTL_TB] && s.cnt[s.ch] != cntStep &&
               req[s.ch]) begin
            start = 1'b1;
            pick = s.ch;
         end else begin
            next_s.fsm = dma_pkg::ST_IDLE;
            next_s.busReq = 1'b0;
            next_s.busWrite = 1'b0;
            next_s.ack = 2'h0;
            next_s.burst = 1'b0;
         end
      end
      // Start of one unit on the chosen channel
      if (start) begin
         cw = s.ctl[pick];
         ts = cw[dma_pkg::CTL_TS_HI:dma_pkg::CTL_TS_LO];
         next_s.ch = pick;
         next_s.lastCh = pick;
         next_s.pend[pick] = 1'b0;
         next_s.beat = 2'h0;
         next_s.busReq = 1'b1;
         next_s.busSize = (ts == dma_pkg::TS_BLK16) ? dma_pkg::TS_LONG : ts;
         next_s.burst = (ts == dma_pkg::TS_BLK16);
         next_s.busWdata = 32'h00000000;
         next_s.ack = 2'h0;
         if (!cw[dma_pkg::CTL_TA] || cw[dma_pkg::CTL_AM]) begin
            next_s.fsm = dma_pkg::ST_READ;
            next_s.busWrite = 1'b0;
            next_s.busAddr = s.src[pick];
            next_s.ack[pick] = ackOn(cw, s.rsel[pick][1:0], 1'b0);
         end else begin
            next_s.fsm = dma_pkg::ST_WRITE;
            next_s.busWrite = 1'b1;
            next_s.busAddr = s.dst[pick];
            next_s.ack[pick] = ackOn(cw, s.rsel[pick][1:0], 1'b1);
         end
      end
      // Completion interrupt requests
      for (int c = 0; c < 2; c++) begin
         next_s.irq[c] = next_s.ctl[c][dma_pkg::CTL_TE] &
            next_s.ctl[c][dma_pkg::CTL_IE];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
         s.fsm <= dma_pkg::ST_IDLE;
      end else begin
         s <= next_s;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign regRdata = s.regRdata;
   assign busReq = s.busReq;
   assign busWrite = s.busWrite;
   assign busAddr = s.busAddr;
   assign busSize = s.busSize;
   assign busWdata = s.busWdata;
   assign burst_hint_out = s.burst;
   assign xfer_ack_out_ch0 = s.ack[0];
   assign xfer_ack_out_ch1 = s.ack[1];
   assign irqCh0 = s.irq[0];
   assign irqCh1 = s.irq[1];
endmodule : dma_controller

// ===== src/dma_pkg.sv
// Purpose: Shared constants and types for the two-channel transfer engine
// Assumes: Registers sit at their printed offsets on a plain register port
// Notes: Reset values of address, count and vector registers are zero

package dma_pkg;

   // Register offsets
   localparam logic [31:0] OFS_C0_SRC = 32'hFFFFFF80;
   localparam logic [31:0] OFS_C0_DST = 32'hFFFFFF84;
   localparam logic [31:0] OFS_C0_CNT = 32'hFFFFFF88;
   localparam logic [31:0] OFS_C0_CTL = 32'h0FFFFF8C;
   localparam logic [31:0] OFS_C0_VEC = 32'hFFFFFFA0;
   localparam logic [31:0] OFS_C0_RSEL = 32'hFFFFFE71;
   localparam logic [31:0] OFS_C1_SRC = 32'h0FFFFF90;
   localparam logic [31:0] OFS_C1_DST = 32'hFFFFFF94;
   localparam logic [31:0] OFS_C1_CNT = 32'h0FFFFF98;
   localparam logic [31:0] OFS_C1_CTL = 32'h0FFFFF9C;
   localparam logic [31:0] OFS_C1_VEC = 32'hFFFFFFA8;
   localparam logic [31:0] OFS_C1_RSEL = 32'hFFFFFE72;
   localparam logic [31:0] OFS_OP = 32'h0FFFFFB0;

   // Register kinds returned by the address decoder
   typedef enum logic [2:0] {
      K_NONE, K_SRC, K_DST, K_CNT, K_CTL, K_VEC, K_RSEL, K_OP
   } kind_type;

   // Channel control field positions
   localparam int CTL_DM_HI = 15;
   localparam int CTL_DM_LO = 14;
   localparam int CTL_SM_HI = 13;
   localparam int CTL_SM_LO = 12;
   localparam int CTL_TS_HI = 11;
   localparam int CTL_TS_LO = 10;
   localparam int CTL_AR = 9;
   localparam int CTL_AM = 8;
   localparam int CTL_DS = 6;
   localparam int CTL_DL = 5;
   localparam int CTL_TB = 4;
   localparam int CTL_TA = 3;
   localparam int CTL_IE = 2;
   localparam int CTL_TE = 1;
   localparam int CTL_DE = 0;
   localparam int CTL_W = 16;

   // Shared operation field positions
   localparam int OP_DME = 0;
   localparam int OP_NMIF = 1;
   localparam int OP_AE = 2;
   localparam int OP_PR = 3;
   localparam int OP_W = 4;

   // Request source select field
   localparam int RSEL_HI = 1;
   localparam int RSEL_LO = 0;
   localparam logic [1:0] RSEL_PIN = 2'h0;

   // Transfer sizes and address modes
   localparam logic [1:0] TS_BYTE = 2'h0;
   localparam logic [1:0] TS_WORD = 2'h1;
   localparam logic [1:0] TS_LONG = 2'h2;
   localparam logic [1:0] TS_BLK16 = 2'h3;
   localparam logic [1:0] AM_INC = 2'h1;
   localparam logic [1:0] AM_DEC = 2'h2;
   localparam logic [31:0] STEP_BYTE = 32'h00000001;
   localparam logic [31:0] STEP_WORD = 32'h00000002;
   localparam logic [31:0] STEP_LONG = 32'h00000004;
   localparam logic [31:0] STEP_BLK16 = 32'h00000010;
   localparam logic [1:0] BEATS_BLK16 = 2'h3;

   // Transfer count
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
   localparam logic [CNT_W-1:0] CNT_BLK16 = 24'h000004;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} fsm_type;

endpackage : dma_pkg

// ===== verif/dma_controller_props.sv
// Purpose: Port checker for the two-channel transfer engine
// Assumes: Only the top ports are visible
// Notes: Bound to every engine instance
`timescale 1ns/10ps
module dma_controller_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   input wire logic busReq,
   input wire logic busAck,
   input wire logic busWrite,
   input wire logic [31:0] busAddr,
   input wire logic [1:0] busSize,
   input wire logic [31:0] busWdata,
   input wire logic burst_hint_out,
   input wire logic xfer_ack_out_ch0,
   input wire logic xfer_ack_out_ch1
);
   logic [2:0] hintBeats;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // Beats taken within the current block unit
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hintBeats <= 3'h0;
      end else if (busReq && busAck && burst_hint_out) begin
         hintBeats <= hintBeats + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Relations between ports
   property p_rd_slot;
      !$past(regRead) |-> regRdata == 32'h0;
   endproperty
   a_rd_slot: assert property (p_rd_slot)
      else $error("read data outside its slot");
   property p_ack_bus;
      xfer_ack_out_ch0 || xfer_ack_out_ch1 |-> busReq;
   endproperty
   a_ack_bus: assert property (p_ack_bus)
      else $error("acknowledge without a beat");
   property p_ack_one;
      !(xfer_ack_out_ch0 && xfer_ack_out_ch1);
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("both acknowledges high");
   property p_hold;
      busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busWdata)
         && $stable(busWrite) && $stable(xfer_ack_out_ch0);
   endproperty
   a_hold: assert property (p_hold)
      else $error("beat changed before acceptance");
   property p_size;
      busReq |-> busSize != 2'h3;
   endproperty
   a_size: assert property (p_size)
      else $error("illegal beat size");
   property p_hint_long;
      burst_hint_out && busReq |-> busSize == 2'h2 && busAddr[1:0] == 2'h0;
   endproperty
   a_hint_long: assert property (p_hint_long)
      else $error("block beat not an aligned longword");
   property p_hint_order;
      burst_hint_out && busReq |-> busWrite == hintBeats[2];
   endproperty
   a_hint_order: assert property (p_hint_order)
      else $error("block beats not four reads then four writes");
   property p_hint_next;
      busReq && busAck && burst_hint_out && hintBeats != 3'h7 |-> ##[1:2] busReq;
   endproperty
   a_hint_next: assert property (p_hint_next)
      else $error("block unit broken off");
   // Main scenarios seen
   c_block: cover property (busReq && busAck && burst_hint_out);
   c_single: cover property (busReq && busAck && xfer_ack_out_ch0);
   c_write: cover property (busReq && busAck && busWrite);
endmodule : dma_controller_props

bind dma_controller dma_controller_props i_props (.clk_sys, .rst_n,
   .regRead, .regRdata, .busReq, .busAck, .busWrite, .busAddr, .busSize,
   .busWdata, .burst_hint_out, .xfer_ack_out_ch0, .xfer_ack_out_ch1);

// ===== verif/bus_memory_model.sv
// Purpose: Memory slave on the engine's bus side
// Assumes: Word-indexed store of 64 words
// Notes: Read data idles at the inverse of its last value
`timescale 1ns/10ps
module bus_memory_model (
   input wire logic clk_sys,
   input wire logic busReq,
   input wire logic busWrite,
   input wire logic [31:0] busAddr,
   input wire logic [31:0] busWdata,
   input wire logic [1:0] waitCycles,
   output logic busAck,
   output logic [31:0] busRdata
);
   logic [31:0] mem [64];
   logic [31:0] lastRd = 32'h0;
   logic [1:0] waitCnt = 2'h0;
   // Known pattern in the store
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 32'hC0DE0000 + 32'(i);
      end
   end
   // Beat accepted once the wait count runs out
   assign busAck = busReq && (waitCnt == waitCycles);
   assign busRdata = (busAck && !busWrite) ? mem[busAddr[7:2]] : ~lastRd;
   // Stretch beats, store writes
   always @(posedge clk_sys) begin
      waitCnt <= (busReq && !busAck) ? waitCnt + 2'h1 : 2'h0;
      if (busAck && busWrite) begin
         mem[busAddr[7:2]] <= busWdata;
      end
      if (busAck && !busWrite) begin
         lastRd <= busRdata;
      end
   end
endmodule : bus_memory_model

// ===== verif/test_two_channel_dma_controller.sv
// Purpose: Self-checking bench for the two-channel transfer engine
// Assumes: Memory slave answers beats, bench drives request pin
// Notes: Unused request sources held idle
`timescale 1ns/10ps
module test_two_channel_dma_controller;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] regAddr = 32'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic reqPin = 1'b0;
   logic [1:0] waitCycles = 2'h0;
   logic [31:0] regRdata, busRdata, busAddr, busWdata;
   logic busAck, busReq, busWrite, burstHint, ack0, ack1, irq0, irq1;
   logic [1:0] busSize;
   int error_cnt = 0;
   int check_count = 0;
   int beatCnt = 0;
   int ackCnt = 0;
   int hintCnt = 0;
   // Clock
   always #50 clk_sys = ~clk_sys;
   dma_controller i_dut (.clk_sys, .rst_n, .regAddr, .regWdata, .regWrite,
      .regRead, .regRdata, .xfer_request_in_ch0(reqPin),
      .xfer_request_in_ch1(1'b0), .periphReqCh0(3'h0), .periphReqCh1(3'h0),
      .nmiIn(1'b0), .busAck, .busError(1'b0), .busRdata, .busReq, .busWrite,
      .busAddr, .busSize, .busWdata, .burst_hint_out(burstHint),
      .xfer_ack_out_ch0(ack0), .xfer_ack_out_ch1(ack1), .irqCh0(irq0),
      .irqCh1(irq1));
   bus_memory_model i_mem (.clk_sys, .busReq, .busWrite, .busAddr,
      .busWdata, .waitCycles, .busAck, .busRdata);
   // Count accepted beats
   always @(posedge clk_sys) begin
      if (busReq && busAck) begin
         beatCnt++;
         ackCnt += int'(ack0);
         hintCnt += int'(burstHint);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rc(input logic [31:0] a, input logic [31:0] exp);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(negedge clk_sys);
      chk(regRdata, exp);
      @(posedge clk_sys);
   endtask : rc
   task automatic wait_irq(input int ch);
      int n = 0;
      while ((ch ? irq1 : irq0) !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(ch ? irq1 : irq0), 32'h1);
   endtask : wait_irq
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rc(dma_pkg::OFS_C0_CTL, 32'h0);
      rc(dma_pkg::OFS_C0_RSEL, 32'h0);
      wr(dma_pkg::OFS_C1_CTL, 32'h00000002);
      rc(dma_pkg::OFS_C1_CTL, 32'h0);
      wr(dma_pkg::OFS_OP, 32'h00000006);
      rc(dma_pkg::OFS_OP, 32'h0);
      wr(dma_pkg::OFS_C1_RSEL, 32'h00000002);
      rc(dma_pkg::OFS_C1_RSEL, 32'h00000002);
      wr(dma_pkg::OFS_C1_RSEL, 32'h0);
      wr(dma_pkg::OFS_C0_CNT, 32'hAB000005);
      rc(dma_pkg::OFS_C0_CNT, 32'h00000005);
      wr(dma_pkg::OFS_C1_VEC, 32'h0000003C);
      rc(dma_pkg::OFS_C1_VEC, 32'h0000003C);
      rc(32'hFFFFFF70, 32'h0);
   endtask : t_regs
   task automatic t_dual;
      beatCnt = 0;
      wr(dma_pkg::OFS_C0_SRC, 32'h00000010);
      wr(dma_pkg::OFS_C0_DST, 32'h00000040);
      wr(dma_pkg::OFS_C0_CNT, 32'h00000002);
      wr(dma_pkg::OFS_OP, 32'h00000009);
      rc(dma_pkg::OFS_OP, 32'h00000009);
      wr(dma_pkg::OFS_C0_CTL, 32'h00005A05);
      wait_irq(0);
      chk(i_mem.mem[16], 32'hC0DE0004);
      chk(i_mem.mem[17], 32'hC0DE0005);
      chk(beatCnt, 4);
      rc(dma_pkg::OFS_C0_SRC, 32'h00000018);
      rc(dma_pkg::OFS_C0_CNT, 32'h0);
      rc(dma_pkg::OFS_C0_CTL, 32'h00005A07);
      wr(dma_pkg::OFS_C0_CTL, 32'h00005A04);
      rc(dma_pkg::OFS_C0_CTL, 32'h00005A04);
      chk(32'(irq0), 32'h0);
   endtask : t_dual
   task automatic t_block;
      beatCnt = 0;
      hintCnt = 0;
      waitCycles <= 2'h2;
      wr(dma_pkg::OFS_C1_SRC, 32'h00000080);
      wr(dma_pkg::OFS_C1_DST, 32'h000000C0);
      wr(dma_pkg::OFS_C1_CNT, 32'h00000004);
      wr(dma_pkg::OFS_C1_CTL, 32'h00004E05);
      wait_irq(1);
      for (int i = 0; i < 4; i++) begin
         chk(i_mem.mem[48 + i], 32'hC0DE0020 + 32'(i));
      end
      chk(beatCnt, 8);
      chk(hintCnt, 8);
      rc(dma_pkg::OFS_C1_SRC, 32'h00000090);
      rc(dma_pkg::OFS_C1_DST, 32'h000000D0);
      waitCycles <= 2'h0;
   endtask : t_block
   task automatic t_single;
      beatCnt = 0;
      ackCnt = 0;
      wr(dma_pkg::OFS_C0_SRC, 32'h00000020);
      wr(dma_pkg::OFS_C0_CNT, 32'h00000001);
      wr(dma_pkg::OFS_C0_CTL, 32'h0000192D);
      reqPin <= 1'b1;
      wait_irq(0);
      chk(beatCnt, 1);
      chk(ackCnt, 1);
      rc(dma_pkg::OFS_C0_SRC, 32'h00000024);
      // Edge mode, low active: a held inactive pin starts nothing
      rc(dma_pkg::OFS_C0_CTL, 32'h0000192F);
      wr(dma_pkg::OFS_C0_CNT, 32'h00000001);
      wr(dma_pkg::OFS_C0_CTL, 32'h0000194D);
      repeat (4) @(posedge clk_sys);
      chk(beatCnt, 1);
      reqPin <= 1'b0;
      wait_irq(0);
      chk(beatCnt, 2);
      chk(ackCnt, 2);
      rc(dma_pkg::OFS_C0_SRC, 32'h00000028);
   endtask : t_single
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_dual();
      t_block();
      t_single();
      stop_test();
   end
   // Watchdog
   initial begin
      #2000000;
      error_cnt++;
      stop_test();
   end
endmodule : test_two_channel_dma_controller
